// >>> tws_sequencer.sv
// two-wire serial port: general call slave, repeated start and acknowledge master
//
// Operation
// - general call recognised only while general_call_enable is set.
// - after start, shift 8 bits, compare with own and general call address.
// - on general call, load buffer, set buffer full; irq at ninth falling clock.
// - in 10-bit mode set address_update_needed after the first address byte.
// - general call in 10-bit mode skips second half and address update.
// - repeated start begins only from idle; then clock line driven low.
// - clock low: reload baud generator from address low bits, release data.
// - expiry with data high releases clock; reload when clock seen high.
// - pull data low one baud period; then clear enable, keep data low.
// - start flag on bus start; irq for repeated start after generator timeout.
// - repeated start written during another event has no effect.
// - collision if data low at clock rise, or clock falls early.
// - buffer write during repeated start sets write collision, buffer kept.
// - low five control bits ignored until repeated start completes.
// - acknowledge enable pulls clock low and drives ack data value.
// - ack: count, release clock, count when high, pull low, clear, idle.
// - buffer write during acknowledge sets write collision, buffer kept.
// - master status read/write bit ored with enables tells idle.
`timescale 1ns/10ps
`include "tws_consts.svh"

module tws_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// two-wire bus, open drain
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// event flag to the system
	output logic             irq_flag
);
	import tws_pkg::*;

	// ======================================================================
	// pin synchronisers
	logic       scl_m_q;
	logic       scl_s_q;
	logic       sda_m_q;
	logic       sda_s_q;
	logic       scl_p_q;
	logic       sda_p_q;

	// first stages feed only the second stages
	always_ff @(posedge clk) begin
		if (!resetn) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			scl_p_q <= scl_s_q;
			sda_p_q <= sda_s_q;
		end
	end

	// bus edge and condition decode
	wire scl_rise  = scl_s_q & ~scl_p_q;
	wire scl_fall  = ~scl_s_q & scl_p_q;
	wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// ======================================================================
	// registers
	logic [7:0]    ctrl2_q;
	logic [7:0]    addr_q;
	logic [7:0]    buf_q;
	logic [7:0]    mode_q;
	logic [7:0]    shift_q;
	logic [3:0]    bitcnt_q;
	logic          bf_q;
	logic          ua_q;
	logic          start_q;
	logic          stop_q;
	logic          da_q;
	logic          smp_q;
	logic [6:0]    brg_q;
	logic          brg_run_q;
	tws_state_type st_q;
	tws_slave_type sl_q;
	logic          gc_hit_q;
	logic          sda_drv_q;
	logic          scl_drv_q;
	logic          ack_out_q;

	// apb decode
	wire wr_en  = psel & penable & pwrite;
	wire rd_en  = psel & penable & ~pwrite;
	wire rd_set = psel & ~penable & ~pwrite;
	wire hit_st = paddr == `TWS_OFF_STAT;
	wire hit_c2 = paddr == `TWS_OFF_CTRL2;
	wire hit_bf = paddr == `TWS_OFF_BUF;
	wire hit_ad = paddr == `TWS_OFF_ADDR;
	wire hit_md = paddr == `TWS_OFF_MODE;
	wire mapped = hit_st | hit_c2 | hit_bf | hit_ad | hit_md;

	// master activity
	wire in_rs    = (st_q == TWS_RS_LOW) | (st_q == TWS_RS_SDAHI) |
	                (st_q == TWS_RS_SCLHI) | (st_q == TWS_RS_SDALO);
	wire in_ak    = (st_q == TWS_AK_LOW) | (st_q == TWS_AK_SCLHI);
	wire rw_bit   = mode_q[`TWS_MD_MST] ? bf_q : 1'b0; // transmit in progress
	wire idle     = ~(rw_bit | (|ctrl2_q[4:0])) & (st_q == TWS_IDLE);
	wire buf_wr   = wr_en & hit_bf;
	wire write_collision_flag_set = buf_wr & (in_rs | in_ak);
	wire c2_wr    = wr_en & hit_c2;

	// baud generator expires when it reaches zero while running
	wire brg_zero = brg_run_q & (brg_q == 7'h00);

	// slave address compare
	wire gc_match  = ctrl2_q[`TWS_C2_GENERAL_CALL_ENABLE] & (shift_q == `TWS_GCALL);
	wire own_match = shift_q[7:1] == addr_q[7:1];

	// status register image
	wire [7:0] stat_img = {smp_q, 1'b0, da_q, stop_q, start_q, rw_bit, ua_q, bf_q};

	// read mux, unmapped reads return zero
	wire [7:0] rd_byte = hit_st ? stat_img :
	                     hit_c2 ? ctrl2_q  :
	                     hit_bf ? buf_q    :
	                     hit_ad ? addr_q   :
	                     hit_md ? mode_q   : 8'h00;

	// one-cycle answer: pready always high, error for unmapped addresses
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ======================================================================
	// apb read data, captured in setup so it already stands at the access edge
	always_ff @(posedge clk) begin
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (rd_set)
			prdata <= {24'h00_0000, rd_byte};
	end

	// ======================================================================
	// baud generator, reload from the low seven address bits
	wire brg_load_rs = (st_q == TWS_RS_LOW & ~scl_s_q) |
	                   (st_q == TWS_RS_SDAHI & brg_zero & sda_s_q & scl_rise) |
	                   (st_q == TWS_RS_SCLHI & brg_zero);
	wire brg_load    = brg_load_rs | (c2_wr & idle & pwdata[`TWS_C2_ACK_SEQUENCE_ENABLE]) |
	                   (st_q == TWS_AK_LOW & brg_zero & scl_s_q);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			brg_q     <= 7'h00;
			brg_run_q <= 1'b0;
		end else if (brg_load) begin
			brg_q     <= addr_q[6:0];
			brg_run_q <= 1'b1;
		end else if (st_q == TWS_IDLE) begin
			brg_run_q <= 1'b0;
		end else if (brg_run_q && brg_q != 7'h00) begin
			brg_q <= brg_q - 7'h01;
		end
	end

	// ======================================================================
	// master sequencer: repeated start and acknowledge
	wire rs_go  = c2_wr & idle & pwdata[`TWS_C2_REPEATED_START_ENABLE];
	wire ak_go  = c2_wr & idle & pwdata[`TWS_C2_ACK_SEQUENCE_ENABLE] & ~pwdata[`TWS_C2_REPEATED_START_ENABLE];
	wire rs_col = (st_q == TWS_RS_SDAHI & scl_rise & ~sda_s_q) |
	              (st_q == TWS_RS_SCLHI & scl_fall) |
	              (st_q == TWS_RS_SDAHI & scl_fall & ~scl_drv_q);
	wire rs_done = st_q == TWS_RS_SDALO & brg_zero;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q      <= TWS_IDLE;
			scl_drv_q <= 1'b0;
			sda_drv_q <= 1'b0;
		end else if (rs_col) begin
			st_q      <= TWS_IDLE;
			scl_drv_q <= 1'b0;
			sda_drv_q <= 1'b0;
		end else begin
			unique case (st_q)
				TWS_IDLE: begin
					if (rs_go) begin
						st_q      <= TWS_RS_LOW;
						scl_drv_q <= 1'b1;
					end else if (ak_go) begin
						st_q      <= TWS_AK_LOW;
						scl_drv_q <= 1'b1;
						sda_drv_q <= ~pwdata[`TWS_C2_ACK_DATA_VALUE]; // new value of this write
					end
				end
				TWS_RS_LOW: begin
					if (!scl_s_q) begin
						st_q      <= TWS_RS_SDAHI;
						sda_drv_q <= 1'b0;
					end
				end
				TWS_RS_SDAHI: begin
					if (brg_zero && sda_s_q && scl_drv_q)
						scl_drv_q <= 1'b0;
					else if (!scl_drv_q && scl_rise)
						st_q <= TWS_RS_SCLHI;
				end
				TWS_RS_SCLHI: begin
					if (brg_zero) begin
						st_q      <= TWS_RS_SDALO;
						sda_drv_q <= 1'b1;
					end
				end
				TWS_RS_SDALO: begin
					if (brg_zero)
						st_q <= TWS_IDLE; // data line stays low
				end
				TWS_AK_LOW: begin
					if (brg_zero && scl_drv_q)
						scl_drv_q <= 1'b0;
					else if (!scl_drv_q && scl_s_q)
						st_q <= TWS_AK_SCLHI;
				end
				TWS_AK_SCLHI: begin
					if (brg_zero) begin
						st_q      <= TWS_IDLE;
						scl_drv_q <= 1'b1;
						sda_drv_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// ======================================================================
	// second serial control: low five bits locked while sequences run
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl2_q <= `TWS_C2_RST;
		end else begin
			if (c2_wr) begin
				ctrl2_q[7:5] <= pwdata[7:5];
				if (idle)
					ctrl2_q[4:0] <= pwdata[4:0];
			end
			if (rs_done || rs_col)
				ctrl2_q[`TWS_C2_REPEATED_START_ENABLE] <= 1'b0;
			if (st_q == TWS_AK_SCLHI && brg_zero)
				ctrl2_q[`TWS_C2_ACK_SEQUENCE_ENABLE] <= 1'b0;
		end
	end

	// ======================================================================
	// slave receive: address byte, general call, data
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sl_q     <= TWS_SL_IDLE;
			shift_q  <= 8'h00;
			bitcnt_q <= 4'h0;
			gc_hit_q <= 1'b0;
			ack_out_q <= 1'b0;
		end else if (bus_start) begin
			sl_q     <= TWS_SL_ADDR;
			bitcnt_q <= 4'h0;
			gc_hit_q <= 1'b0;
		end else if (bus_stop) begin
			sl_q <= TWS_SL_IDLE;
			ack_out_q <= 1'b0;
		end else begin
			unique case (sl_q)
				TWS_SL_IDLE: ;
				TWS_SL_ADDR, TWS_SL_DATA: begin
					if (scl_rise && bitcnt_q != 4'h8) begin
						shift_q  <= {shift_q[6:0], sda_s_q};
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (bitcnt_q == 4'h8 && scl_fall) begin
						bitcnt_q  <= 4'h0;
						if (sl_q == TWS_SL_ADDR)
							gc_hit_q <= gc_match;
						ack_out_q <= (sl_q == TWS_SL_ADDR) ? (gc_match | own_match)
						                                   : gc_hit_q;
						sl_q      <= (sl_q == TWS_SL_ADDR && !(gc_match | own_match))
						             ? TWS_SL_IDLE : TWS_SL_ACK;
					end
				end
				TWS_SL_ACK: begin
					if (scl_fall) begin
						ack_out_q <= 1'b0;
						sl_q      <= TWS_SL_DATA;
					end
				end
			endcase
		end
	end

	// ninth clock: falling edge that ends the acknowledge slot
	wire ninth_fall = sl_q == TWS_SL_ACK & scl_fall;
	wire eighth     = (sl_q == TWS_SL_ADDR | sl_q == TWS_SL_DATA) &
	                  bitcnt_q == 4'h8 & scl_fall;
	wire gc_load    = eighth & (sl_q == TWS_SL_ADDR ? gc_match : gc_hit_q);

	// ======================================================================
	// status flags and buffer; hardware set wins over software clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			buf_q   <= 8'h00;
			addr_q  <= 8'h00;
			mode_q  <= `TWS_MD_RST;
			bf_q    <= 1'b0;
			ua_q    <= 1'b0;
			start_q <= 1'b0;
			stop_q  <= 1'b0;
			da_q    <= 1'b0;
			smp_q   <= 1'b0;
		end else begin
			if (wr_en && hit_ad) begin
				addr_q <= pwdata[7:0];
				ua_q   <= 1'b0;
			end
			if (wr_en && hit_st)
				smp_q <= pwdata[`TWS_ST_SMP];
			if (wr_en && hit_md)
				mode_q <= pwdata[7:0];
			if (buf_wr && !(in_rs || in_ak))
				buf_q <= pwdata[7:0];
			if (rd_en && hit_bf)
				bf_q <= 1'b0;
			if (gc_load) begin
				buf_q <= shift_q;
				bf_q  <= 1'b1;
				da_q  <= sl_q == TWS_SL_DATA;
			end
			if (eighth && sl_q == TWS_SL_ADDR && mode_q[`TWS_MD_TEN] && !gc_match && own_match)
				ua_q <= 1'b1;
			if (bus_start) begin
				start_q <= 1'b1;
				stop_q  <= 1'b0;
			end
			if (bus_stop) begin
				stop_q  <= 1'b1;
				start_q <= 1'b0;
			end
			if (write_collision_flag_set)
				mode_q[`TWS_MD_WRITE_COLLISION_FLAG] <= 1'b1;
			if (rs_col)
				mode_q[`TWS_MD_BCOL] <= 1'b1;
			if ((ninth_fall && gc_hit_q) || rs_done || rs_col ||
			    (st_q == TWS_AK_SCLHI && brg_zero))
				mode_q[`TWS_MD_IRQ] <= 1'b1;
		end
	end

	// ======================================================================
	// open-drain pins: output always low, enable when pulling
	assign scl_out  = 1'b0;
	assign sda_out  = 1'b0;
	assign scl_oe   = scl_drv_q;
	assign sda_oe   = sda_drv_q | ack_out_q;
	assign irq_flag = mode_q[`TWS_MD_IRQ];

endmodule : tws_sequencer

// >>> tws_consts.svh
// register offsets, field positions and reset values of the two-wire sequencer
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ==========================================================================
// register indexes; each register is one aligned 32-bit word
`define TWS_IDX_STAT     10'h094
`define TWS_IDX_CTRL2    10'h091
`define TWS_IDX_BUF      10'h013
`define TWS_IDX_ADDR     10'h093
`define TWS_IDX_MODE     10'h014

// ==========================================================================
// register byte addresses, four times the index
`define TWS_OFF_STAT     {`TWS_IDX_STAT, 2'b00}
`define TWS_OFF_CTRL2    {`TWS_IDX_CTRL2, 2'b00}
`define TWS_OFF_BUF      {`TWS_IDX_BUF, 2'b00}
`define TWS_OFF_ADDR     {`TWS_IDX_ADDR, 2'b00}
`define TWS_OFF_MODE     {`TWS_IDX_MODE, 2'b00}

// ==========================================================================
// serial_port_status fields
`define TWS_ST_SMP       7
`define TWS_ST_DA        5
`define TWS_ST_STOP      4
`define TWS_ST_START     3
`define TWS_ST_RW        2
`define TWS_ST_UA        1
`define TWS_ST_BF        0
`define TWS_STAT_RST     8'h00

// ==========================================================================
// second_serial_control fields
`define TWS_C2_GENERAL_CALL_ENABLE      7
`define TWS_C2_ACK_DATA_VALUE      5
`define TWS_C2_ACK_SEQUENCE_ENABLE      4
`define TWS_C2_MASTER_RECEIVE_ENABLE      3
`define TWS_C2_PEN       2
`define TWS_C2_REPEATED_START_ENABLE      1
`define TWS_C2_SEN       0
`define TWS_C2_RST       8'h00

// ==========================================================================
// mode register fields: collision flags, master enable, 10-bit slave, irq flag
`define TWS_MD_WRITE_COLLISION_FLAG      7
`define TWS_MD_BCOL      6
`define TWS_MD_IRQ       5
`define TWS_MD_TEN       1
`define TWS_MD_MST       0
`define TWS_MD_RST       8'h00

// general call address with write direction
`define TWS_GCALL        8'h00

`endif

// >>> tws_pkg.sv
// types shared by the two-wire sequencer
package tws_pkg;
	// master sequence state
	typedef enum logic [2:0] {
		TWS_IDLE,
		TWS_RS_LOW,
		TWS_RS_SDAHI,
		TWS_RS_SCLHI,
		TWS_RS_SDALO,
		TWS_AK_LOW,
		TWS_AK_SCLHI
	} tws_state_type;

	// slave receive state
	typedef enum logic [1:0] {
		TWS_SL_IDLE,
		TWS_SL_ADDR,
		TWS_SL_ACK,
		TWS_SL_DATA
	} tws_slave_type;
endpackage : tws_pkg

// >>> tws_chk_sva.sv
// port checker of the two-wire sequencer
`timescale 1ns/10ps
`include "tws_consts.svh"

module tws_chk (
	// clock, reset and apb
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// two-wire pins and event flag
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        irq_flag
);
	// ==========================================================
	// decode and helpers
	wire        acc    = psel && penable;
	wire        c2_wr  = acc && pwrite && paddr == `TWS_OFF_CTRL2;
	wire        mapped = paddr inside {`TWS_OFF_STAT, `TWS_OFF_CTRL2, `TWS_OFF_BUF,
		`TWS_OFF_ADDR, `TWS_OFF_MODE};
	logic [9:0] quiet_q;
	logic [7:0] low_q;
	logic [6:0] reload_q;
	logic       rs_q;
	wire        idle   = quiet_q == 10'h3ff;
	// a long quiet after a control write stands in for an idle sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			quiet_q  <= 10'h000;
			low_q    <= 8'h00;
			reload_q <= 7'h00;
			rs_q     <= 1'b0;
		end else begin
			quiet_q  <= c2_wr ? 10'h000 : (idle ? quiet_q : quiet_q + 10'h001);
			low_q    <= !scl_oe ? 8'h00 : (&low_q ? low_q : low_q + 8'h01);
			reload_q <= (acc && pwrite && paddr == `TWS_OFF_ADDR) ? pwdata[6:0] : reload_q;
			rs_q     <= (c2_wr && idle) ? pwdata[1] : rs_q;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	ready_now_a: assert property (pready) else $error("pready low");
	slverr_map_a: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
	drive_low_a: assert property (!scl_out && !sda_out) else $error("pin driven high");
	reset_quiet_a: assert property ($rose(resetn) |-> !scl_oe && !sda_oe && !irq_flag)
		else $error("outputs live after reset");
	rs_pull_a: assert property (c2_wr && pwdata[4:0] == 5'h02 && idle |-> ##2 scl_oe)
		else $error("clock not pulled");
	ack_drive_a: assert property (c2_wr && pwdata[4:0] == 5'h10 && idle
		|-> ##2 scl_oe && sda_oe == !$past(pwdata[5], 2)) else $error("ack drive wrong");
	clock_hold_a: assert property ($fell(scl_oe) |-> low_q >= {1'b0, reload_q})
		else $error("clock low too short");
	sda_keep_a: assert property (rs_q && sda_oe && !scl_oe && !c2_wr |=> sda_oe)
		else $error("data released early");
endmodule : tws_chk

bind tws_sequencer tws_chk u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .scl_out, .scl_oe, .sda_out, .sda_oe, .irq_flag);

// >>> tws_far_end.sv
// far-end model: pull-ups, clock stretch, line faults and a general call master
`timescale 1ns/10ps

module tws_far_end (
	// pull enables of the block
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	// resolved line levels
	output wire logic scl_line,
	output wire logic sda_line
);
	logic scl_low = 1'b0;
	logic sda_low = 1'b0;
	// open drain with pull-ups, so a released line reads high
	assign scl_line = !(scl_oe || scl_low);
	assign sda_line = !(sda_oe || sda_low);
	task automatic hold(input logic c, input logic d);
		scl_low = c;
		sda_low = d;
	endtask : hold
	// start, eight bits msb first, ninth clock for the answer, then stop
	task automatic send(input logic [7:0] b, output logic acked);
		sda_low = 1'b1;
		#62;
		for (int i = 8; i >= 0; i--) begin
			scl_low = 1'b1;
			#31;
			sda_low = (i > 0) ? !b[i-1] : 1'b0;
			#31;
			scl_low = 1'b0;
			#31;
			acked = !sda_line;
			#32;
		end
		scl_low = 1'b1;
		sda_low = 1'b1;
		#62;
		scl_low = 1'b0;
		#62;
		sda_low = 1'b0;
	endtask : send
endmodule : tws_far_end

// >>> tws_tb.sv
// self-checking bench of the two-wire sequencer
`timescale 1ns/10ps
`include "tws_consts.svh"

module testbench;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, scl_oe, sda_oe, scl_out, sda_out, irq_flag;
	logic        scl_ln, sda_ln, ack, er;
	logic [7:0]  rq;
	int          err_count = 0;
	int          n_checks = 0;
	// the far end resolves both lines
	tws_far_end far (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_ln), .sda_line(sda_ln));
	tws_sequencer DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .scl_in(scl_ln), .scl_out, .scl_oe, .sda_in(sda_ln), .sda_out,
		.sda_oe, .irq_flag);
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one apb transfer; data taken at the access edge, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			wrap_up();
		end
		er = pslverr;
		rq = prdata[7:0];
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic poll(input logic [7:0] m);
		int n = 0;
		do begin
			apb(1'b0, `TWS_OFF_CTRL2, 8'h00);
			n++;
		end while ((rq & m) !== 8'h00 && n < 300);
		if (n >= 300) begin
			err_count++;
			wrap_up();
		end
	endtask : poll
	task automatic t_regs;
		apb(1'b0, `TWS_OFF_STAT, 8'h00);
		chk("status", rq, `TWS_STAT_RST);
		apb(1'b0, 12'h0f0, 8'h00);
		chk("slverr", 8'(er), 8'h01);
		chk("hole", rq, 8'h00);
		$display("done registers");
	endtask : t_regs
	task automatic t_gcall;
		apb(1'b1, `TWS_OFF_ADDR, 8'h02);
		apb(1'b1, `TWS_OFF_MODE, 8'h02);
		far.send(`TWS_GCALL, ack);
		cyc(4);
		chk("ack off", 8'({ack, irq_flag}), 8'h00);
		apb(1'b1, `TWS_OFF_CTRL2, 8'h80);
		// a non-zero preload shows that the buffer really takes the address
		apb(1'b1, `TWS_OFF_BUF, 8'h5c);
		far.send(`TWS_GCALL, ack);
		cyc(4);
		chk("ack on", 8'({ack, irq_flag}), 8'h03);
		apb(1'b0, `TWS_OFF_STAT, 8'h00);
		chk("full", rq & 8'h03, 8'h01);
		apb(1'b0, `TWS_OFF_BUF, 8'h00);
		chk("buffer", rq, `TWS_GCALL);
		// own first address byte in 10-bit mode asks for an address update
		far.send(8'h02, ack);
		cyc(4);
		apb(1'b0, `TWS_OFF_STAT, 8'h00);
		chk("update", {6'h00, ack, rq[`TWS_ST_UA]}, 8'h03);
		apb(1'b1, `TWS_OFF_MODE, 8'h00);
		$display("done general call");
	endtask : t_gcall
	// stretched repeated start with a buffer write and a queued enable refused
	task automatic t_rstart;
		apb(1'b1, `TWS_OFF_ADDR, 8'h03);
		apb(1'b1, `TWS_OFF_MODE, 8'h01);
		cyc(1100);
		apb(1'b1, `TWS_OFF_CTRL2, 8'h02);
		cyc(2);
		chk("pull", 8'(scl_oe), 8'h01);
		far.hold(1'b1, 1'b0);
		apb(1'b1, `TWS_OFF_BUF, 8'ha5);
		apb(1'b1, `TWS_OFF_CTRL2, 8'h12);
		cyc(30);
		chk("irq early", 8'(irq_flag), 8'h00);
		far.hold(1'b0, 1'b0);
		poll(8'h02);
		chk("ctl", rq, 8'h00);
		chk("lines", 8'({scl_oe, sda_oe, irq_flag}), 8'h03);
		apb(1'b0, `TWS_OFF_STAT, 8'h00);
		chk("start", rq & 8'h08, 8'h08);
		apb(1'b0, `TWS_OFF_MODE, 8'h00);
		chk("mode", rq, 8'ha1);
		apb(1'b0, `TWS_OFF_BUF, 8'h00);
		chk("kept", rq, `TWS_GCALL);
		// once the sequence is over software loads the first address byte
		apb(1'b1, `TWS_OFF_BUF, 8'h3c);
		apb(1'b0, `TWS_OFF_BUF, 8'h00);
		chk("loaded", rq, 8'h3c);
		apb(1'b1, `TWS_OFF_MODE, 8'h01);
		$display("done repeated start");
	endtask : t_rstart
	task automatic t_ack;
		for (int k = 1; k >= 0; k--) begin
			cyc(1100);
			apb(1'b1, `TWS_OFF_CTRL2, k ? 8'h30 : 8'h10);
			cyc(2);
			chk("ack drive", 8'({scl_oe, sda_oe}), k ? 8'h02 : 8'h03);
			apb(1'b1, `TWS_OFF_BUF, 8'h5a);
			apb(1'b1, `TWS_OFF_CTRL2, 8'h02);
			poll(8'h12);
			chk("ack end", 8'({scl_oe, sda_oe}), 8'h02);
			apb(1'b0, `TWS_OFF_MODE, 8'h00);
			chk("ack mode", rq, 8'ha1);
			apb(1'b0, `TWS_OFF_BUF, 8'h00);
			chk("ack buf", rq, 8'h3c);
			apb(1'b1, `TWS_OFF_MODE, 8'h01);
		end
		$display("done acknowledge");
	endtask : t_ack
	// data held low by another master as the clock rises
	task automatic t_coll;
		int n = 0;
		cyc(1100);
		apb(1'b1, `TWS_OFF_CTRL2, 8'h02);
		// stretch the clock so that its rise comes from the far end
		far.hold(1'b1, 1'b0);
		while (scl_oe !== 1'b0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		if (n >= 500) begin
			err_count++;
			wrap_up();
		end
		#1;
		far.hold(1'b1, 1'b1);
		cyc(4);
		#1;
		// clock rises while the other master keeps data low
		far.hold(1'b0, 1'b1);
		cyc(8);
		poll(8'h02);
		far.hold(1'b0, 1'b0);
		chk("released", 8'({scl_oe, sda_oe}), 8'h00);
		apb(1'b0, `TWS_OFF_MODE, 8'h00);
		chk("bus coll", rq & 8'h40, 8'h40);
		$display("done collision");
	endtask : t_coll
	// clock
	initial begin
		forever #4 clk = !clk;
	end
	// main sequence
	initial begin
		cyc(5);
		resetn <= 1'b1;
		cyc(1);
		t_regs();
		t_gcall();
		t_rstart();
		t_ack();
		t_coll();
		wrap_up();
	end
	// hang guard
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
endmodule : testbench
